// *** design/scsf_defines.vh ***
// Purpose: constants for the smart card serial status flag block
// Assumes: byte-wide register port, one 200 MHz clock
// Notes: offsets are byte indexes on the plain register port
//
// Overview of operation
// - smart card flag meanings apply only while smart card select is 1
// - tx buffer empty resets to 1, set while transmit disabled or on shifter load
// - reading tx buffer empty as 1 then writing 0 clears it and transmit end
// - transfer controller write to tx buffer clears tx buffer empty
// - rx buffer full resets to 0, set on error-free reception moved to buffer
// - reading rx buffer full as 1 then writing 0 clears it
// - transfer controller read of rx buffer clears rx buffer full
// - clearing receive enable leaves rx buffer full unchanged
// - overrun resets to 0, set when reception completes while buffer still full
// - reading overrun as 1 then writing 0 clears it
// - error signal flag resets to 0, set when card error signal sampled low while transmit is enabled
// - reading error signal flag as 1 then writing 0 clears it
// - parity error resets to 0, set on parity mismatch in reception
// - reading parity error as 1 then writing 0 clears it
// - transmit end is read-only, resets to 1, set while transmit disabled and no error
// - after a byte, transmit end sets at interval if no error and buffer empty
// - interval 2.5 etu normal, 1.5 etu block mode, 1.0 etu with guard mode
// - rx multiprocessor bit is read-only, resets to 0, unused in smart card mode
`ifndef SCSF_DEFINES_VH
`define SCSF_DEFINES_VH

`define SCSF_ADDR_W 8
`define SCSF_OFS_STATUS 8'h00
`define SCSF_OFS_CTRL 8'h01

`define SCSF_BIT_TXE 7
`define SCSF_BIT_RXF 6
`define SCSF_BIT_OVR 5
`define SCSF_BIT_ERRSIG 4
`define SCSF_BIT_PAR 3
`define SCSF_BIT_TXEND 2
`define SCSF_BIT_MPRX 1
`define SCSF_BIT_MPTX 0

`define SCSF_CTL_SCSEL 0
`define SCSF_CTL_TXEN 1
`define SCSF_CTL_RXEN 2
`define SCSF_CTL_GUARD 3
`define SCSF_CTL_BLOCK 4
`define SCSF_CTL_MASK 8'h1f

`define SCSF_STATUS_RESET 8'h84
`define SCSF_CTRL_RESET 8'h00

// transmit end delays in etu times ten; the tick counts are the same delays in half etu
`define SCSF_TXEND_ETU10_STD 25
`define SCSF_TXEND_ETU10_BLOCK 15
`define SCSF_TXEND_ETU10_GUARD 10
`define SCSF_HALF_STD 3'h5
`define SCSF_HALF_BLOCK 3'h3
`define SCSF_HALF_GUARD 3'h2

`endif

// *** design/scsf_status.v ***
// Purpose: status flags of one serial channel, smart card and normal meanings
// Assumes: engine events are one-cycle pulses on sys_clk; half_etu_tick from the baud divider
// Notes: read-then-write-0 clearing is armed per flag by a status read
//
// Decided for this implementation: the placing of the registers and strobed register access.
`include "scsf_defines.vh"

module scsf_status (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // transmit engine
  input wire tx_load,
  input wire tx_start,
  input wire tx_stop_sent,
  input wire err_sig_low,
  input wire half_etu_tick,
  // receive engine
  input wire rx_done,
  input wire rx_parity_err,
  input wire rx_framing_err,
  input wire rx_mpb_in,
  // transfer controller
  input wire xfer_tx_write,
  input wire xfer_rx_read,
  // flags and control out
  output wire tx_buffer_empty_flag,
  output wire rx_buffer_full_flag,
  output wire overrun_flag,
  output wire error_signal_flag,
  output wire parity_error_flag,
  output wire transmit_end_flag,
  output wire rx_multiproc_bit,
  output wire tx_multiproc_bit,
  output wire smart_card_select,
  output wire transmit_enable,
  output wire receive_enable,
  output wire guard_mode,
  output wire block_mode
);

  // flag registers
  reg txe_r;
  reg txe_nxt;
  reg rxf_r;
  reg rxf_nxt;
  reg ovr_r;
  reg ovr_nxt;
  reg errsig_r;
  reg errsig_nxt;
  reg par_r;
  reg par_nxt;
  reg txend_r;
  reg txend_nxt;
  reg mprx_r;
  reg mprx_nxt;
  reg mptx_r;
  reg mptx_nxt;
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [7:0] arm_r;
  reg [7:0] arm_nxt;
  reg [7:0] rdata_nxt;
  // transmit end interval timer
  reg [2:0] tcnt_r;
  reg [2:0] tcnt_nxt;
  reg trun_r;
  reg trun_nxt;
  reg texp_r;
  reg texp_nxt;

  wire sel_status;
  wire sel_ctrl;
  wire wr_status;
  wire wr_ctrl;
  wire sc_mode;
  wire tx_en;
  wire rx_en;
  wire rx_ok;
  wire [7:0] status_val;
  wire [2:0] end_target;
  wire clr_txe;
  wire clr_rxf;
  wire clr_ovr;
  wire clr_err;
  wire clr_par;

  // a flag clears only if it was read as 1 and 0 is now written
  function clr_ok;
    input armed;
    input wbit;
    input wr_hit;
    begin
      clr_ok = wr_hit & armed & ~wbit;
    end
  endfunction

  // interval in half-etu ticks for the current guard and block settings
  function [2:0] end_half;
    input guard;
    input blk_on;
    begin
      if (guard)
      begin
        end_half = `SCSF_HALF_GUARD;
      end
      else if (blk_on)
      begin
        end_half = `SCSF_HALF_BLOCK;
      end
      else
      begin
        end_half = `SCSF_HALF_STD;
      end
    end
  endfunction

  assign sel_status = (reg_addr == `SCSF_OFS_STATUS);
  assign sel_ctrl = (reg_addr == `SCSF_OFS_CTRL);
  assign wr_status = reg_wr & sel_status;
  assign wr_ctrl = reg_wr & sel_ctrl;
  assign sc_mode = ctrl_r[`SCSF_CTL_SCSEL];
  assign tx_en = ctrl_r[`SCSF_CTL_TXEN];
  assign rx_en = ctrl_r[`SCSF_CTL_RXEN];
  assign rx_ok = rx_done & rx_en;
  assign end_target = end_half(ctrl_r[`SCSF_CTL_GUARD], ctrl_r[`SCSF_CTL_BLOCK]);

  assign status_val = {txe_r, rxf_r, ovr_r, errsig_r, par_r, txend_r, mprx_r, mptx_r};

  // a written 1 never clears
  assign clr_txe = clr_ok(arm_r[`SCSF_BIT_TXE], reg_wdata[`SCSF_BIT_TXE], wr_status);
  assign clr_rxf = clr_ok(arm_r[`SCSF_BIT_RXF], reg_wdata[`SCSF_BIT_RXF], wr_status);
  assign clr_ovr = clr_ok(arm_r[`SCSF_BIT_OVR], reg_wdata[`SCSF_BIT_OVR], wr_status);
  assign clr_err = clr_ok(arm_r[`SCSF_BIT_ERRSIG], reg_wdata[`SCSF_BIT_ERRSIG], wr_status);
  assign clr_par = clr_ok(arm_r[`SCSF_BIT_PAR], reg_wdata[`SCSF_BIT_PAR], wr_status);

  // register port
  always @*
  begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = 8'h00;
    arm_nxt = arm_r;
    if (wr_ctrl)
    begin
      ctrl_nxt = reg_wdata & `SCSF_CTL_MASK;
    end
    // any status write uses up the arming read
    if (wr_status)
    begin
      arm_nxt = 8'h00;
    end
    if (reg_rd)
    begin
      if (sel_status)
      begin
        rdata_nxt = status_val;
        arm_nxt = status_val;
      end
      else if (sel_ctrl)
      begin
        rdata_nxt = ctrl_r;
      end
    end
  end

  // transmit end interval timer, restarted by each transmission start
  always @*
  begin
    tcnt_nxt = tcnt_r;
    trun_nxt = trun_r;
    texp_nxt = 1'b0;
    if (!tx_en)
    begin
      trun_nxt = 1'b0;
    end
    else if (tx_start)
    begin
      trun_nxt = 1'b1;
      tcnt_nxt = end_target;
    end
    else if (trun_r && half_etu_tick)
    begin
      if (tcnt_r == 3'h1)
      begin
        trun_nxt = 1'b0;
        texp_nxt = 1'b1;
      end
      else
      begin
        tcnt_nxt = tcnt_r - 3'h1;
      end
    end
  end

  // flag update; a hardware set always wins over a clear in the same cycle
  always @*
  begin
    txe_nxt = txe_r;
    rxf_nxt = rxf_r;
    ovr_nxt = ovr_r;
    errsig_nxt = errsig_r;
    par_nxt = par_r;
    txend_nxt = txend_r;
    mprx_nxt = mprx_r;
    mptx_nxt = mptx_r;

    // clears
    if (clr_txe || xfer_tx_write)
    begin
      txe_nxt = 1'b0;
      txend_nxt = 1'b0;
    end
    if (clr_rxf || xfer_rx_read)
    begin
      rxf_nxt = 1'b0;
    end
    if (clr_ovr)
    begin
      ovr_nxt = 1'b0;
    end
    if (clr_err)
    begin
      errsig_nxt = 1'b0;
    end
    if (clr_par)
    begin
      par_nxt = 1'b0;
    end
    // the tx multiprocessor bit is plain read/write; smart card software keeps it 0
    if (wr_status)
    begin
      mptx_nxt = reg_wdata[`SCSF_BIT_MPTX];
    end

    // transmit buffer empty sets
    if (!tx_en || tx_load)
    begin
      txe_nxt = 1'b1;
    end

    // receive sets; receive enable low blocks new events but never clears the full flag
    if (rx_ok)
    begin
      if (rxf_r)
      begin
        ovr_nxt = 1'b1;
      end
      else if (rx_parity_err)
      begin
        par_nxt = 1'b1;
      end
      else if (!sc_mode && rx_framing_err)
      begin
        errsig_nxt = 1'b1;
      end
      else
      begin
        rxf_nxt = 1'b1;
        if (!sc_mode)
        begin
          mprx_nxt = rx_mpb_in;
        end
      end
    end

    if (sc_mode)
    begin
      // error signal from the card only counts while transmit is enabled in smart card mode
      if (tx_en && err_sig_low)
      begin
        errsig_nxt = 1'b1;
      end
      if (!tx_en && !errsig_r)
      begin
        txend_nxt = 1'b1;
      end
      else if (texp_r && !errsig_r && txe_nxt)
      begin
        txend_nxt = 1'b1;
      end
      mprx_nxt = mprx_r;
    end
    else
    begin
      // normal meaning: end is reached when the stop bit leaves with no byte waiting
      if (!tx_en || (tx_stop_sent && txe_nxt))
      begin
        txend_nxt = 1'b1;
      end
    end
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      txe_r <= 1'b1;
      rxf_r <= 1'b0;
      ovr_r <= 1'b0;
      errsig_r <= 1'b0;
      par_r <= 1'b0;
      txend_r <= 1'b1;
      mprx_r <= 1'b0;
      mptx_r <= 1'b0;
      ctrl_r <= `SCSF_CTRL_RESET;
      arm_r <= 8'h00;
      reg_rdata <= 8'h00;
      tcnt_r <= 3'h0;
      trun_r <= 1'b0;
      texp_r <= 1'b0;
    end
    else
    begin
      txe_r <= txe_nxt;
      rxf_r <= rxf_nxt;
      ovr_r <= ovr_nxt;
      errsig_r <= errsig_nxt;
      par_r <= par_nxt;
      txend_r <= txend_nxt;
      mprx_r <= mprx_nxt;
      mptx_r <= mptx_nxt;
      ctrl_r <= ctrl_nxt;
      arm_r <= arm_nxt;
      reg_rdata <= rdata_nxt;
      tcnt_r <= tcnt_nxt;
      trun_r <= trun_nxt;
      texp_r <= texp_nxt;
    end
  end

  assign tx_buffer_empty_flag = txe_r;
  assign rx_buffer_full_flag = rxf_r;
  assign overrun_flag = ovr_r;
  assign error_signal_flag = errsig_r;
  assign parity_error_flag = par_r;
  assign transmit_end_flag = txend_r;
  assign rx_multiproc_bit = mprx_r;
  assign tx_multiproc_bit = mptx_r;
  assign smart_card_select = ctrl_r[`SCSF_CTL_SCSEL];
  assign transmit_enable = ctrl_r[`SCSF_CTL_TXEN];
  assign receive_enable = ctrl_r[`SCSF_CTL_RXEN];
  assign guard_mode = ctrl_r[`SCSF_CTL_GUARD];
  assign block_mode = ctrl_r[`SCSF_CTL_BLOCK];

endmodule // scsf_status

// *** verif/scsf_card_model.sv ***
// Purpose: stand-in for the card and the baud divider
// Assumes: half etu tick every 8 clocks, free running
// Notes: the card signals an error only on request
module scsf_card_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // card side
  input wire logic nak_req,
  output logic half_etu_tick,
  output logic err_sig_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 3'h0;
      half_etu_tick <= 1'b0;
      err_sig_low <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 3'h1;
      half_etu_tick <= (div_r == 3'h7);
      err_sig_low <= nak_req;
    end
  end
endmodule // scsf_card_model

// *** verif/scsf_status_assertions.sv ***
// Purpose: port checks of the status flags
// Assumes: one clock, async reset
// Notes: attached by bind
module scsf_status_chk (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // inputs watched
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire err_sig_low,
  input wire rx_done,
  input wire rx_parity_err,
  input wire xfer_rx_read,
  // flags and control
  input wire tx_buffer_empty_flag,
  input wire rx_buffer_full_flag,
  input wire overrun_flag,
  input wire error_signal_flag,
  input wire parity_error_flag,
  input wire transmit_end_flag,
  input wire smart_card_select,
  input wire transmit_enable,
  input wire receive_enable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_rxf;
    rx_done && receive_enable && smart_card_select && !rx_parity_err |=> rx_buffer_full_flag;
  endproperty
  a_rxf: assert property (p_rxf) else $error("rx full not set");
  property p_ovr;
    rx_done && receive_enable && rx_buffer_full_flag |=> overrun_flag;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not set");
  property p_per;
    rx_done && receive_enable && !rx_buffer_full_flag && rx_parity_err |=> parity_error_flag;
  endproperty
  a_per: assert property (p_per) else $error("parity not set");
  property p_ers;
    err_sig_low && smart_card_select && transmit_enable |=> error_signal_flag;
  endproperty
  a_ers: assert property (p_ers) else $error("error signal not set");
  property p_teoff;
    !transmit_enable |=> tx_buffer_empty_flag;
  endproperty
  a_teoff: assert property (p_teoff) else $error("tx empty low");
  property p_transmit_end_flag;
    !transmit_enable && !error_signal_flag && !err_sig_low |=> transmit_end_flag;
  endproperty
  a_transmit_end_flag: assert property (p_transmit_end_flag) else $error("tx end low");
  property p_dtcrx;
    xfer_rx_read && !rx_done |=> !rx_buffer_full_flag;
  endproperty
  a_dtcrx: assert property (p_dtcrx) else $error("rx full kept");
  property p_w1;
    reg_wr && reg_addr == 8'h00 && reg_wdata[6:3] == 4'hf && !rx_done && !xfer_rx_read && !err_sig_low
      |=> $stable({rx_buffer_full_flag, overrun_flag, error_signal_flag, parity_error_flag});
  endproperty
  a_w1: assert property (p_w1) else $error("write one changed flag");
endmodule // scsf_status_chk
bind scsf_status scsf_status_chk scsf_status_chk_inst (.*);

// *** verif/scsf_status_test.sv ***
// Purpose: register-level test of the status flags
// Assumes: status at 0x00, control at 0x01
// Notes: ev bits are tx_load, tx_start, rx_done, xfer write, xfer read, card error
module scsf_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] ev = 6'h00;
  logic par = 1'b0;
  logic fe = 1'b0;
  logic mpbi = 1'b0;
  logic stp = 1'b0;
  wire [7:0] reg_rdata;
  wire tick, nak, txend;
  int n_mismatch = 0;
  int checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  scsf_card_model scsf_card_model_inst (.sys_clk(sys_clk), .rst(rst), .nak_req(ev[5]),
    .half_etu_tick(tick), .err_sig_low(nak));
  scsf_status scsf_status_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_load(ev[0]), .tx_start(ev[1]), .tx_stop_sent(stp), .err_sig_low(nak), .half_etu_tick(tick),
    .rx_done(ev[2]), .rx_parity_err(par), .rx_framing_err(fe), .rx_mpb_in(mpbi),
    .xfer_tx_write(ev[3]), .xfer_rx_read(ev[4]), .tx_buffer_empty_flag(), .rx_buffer_full_flag(),
    .overrun_flag(), .error_signal_flag(), .parity_error_flag(), .transmit_end_flag(txend),
    .rx_multiproc_bit(), .tx_multiproc_bit(), .smart_card_select(), .transmit_enable(),
    .receive_enable(), .guard_mode(), .block_mode());
  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task pulse(input [5:0] v);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 6'h00;
  endtask
  // read then write 0; also keeps the multiprocessor bit at 0
  task clr(input [7:0] exp);
    rd(8'h00, exp);
    wr(8'h00, 8'h00);
  endtask
  // ticks seen from start to tx end must match the mode
  task end_time(input [7:0] mode, input int exp);
    int n;
    int k;
    n = 0;
    wr(8'h01, 8'h07 | mode);
    pulse(6'h01);
    pulse(6'h02);
    #1;
    for (k = 0; k < 200 && txend !== 1'b1; k++)
    begin
      if (tick === 1'b1)
        n++;
      @(posedge sys_clk);
      #1;
    end
    if (k == 200)
    begin
      n_mismatch++;
      $display("BAD t=%0t tx end timeout got=%h exp=%h", $time, n, exp);
    end
    else
      chk(n[7:0], exp[7:0]);
    clr(8'h84);
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h00, 8'h84);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h01, 8'h07);
    clr(8'h84);
    rd(8'h00, 8'h00);
    pulse(6'h01);
    rd(8'h00, 8'h80);
    pulse(6'h08);
    rd(8'h00, 8'h00);
    pulse(6'h04);
    rd(8'h00, 8'h40);
    pulse(6'h04);
    rd(8'h00, 8'h60);
    pulse(6'h10);
    rd(8'h00, 8'h20);
    @(posedge sys_clk);
    par <= 1'b1;
    pulse(6'h04);
    par <= 1'b0;
    rd(8'h00, 8'h28);
    wr(8'h00, 8'h78);
    clr(8'h28);
    rd(8'h00, 8'h00);
    pulse(6'h04);
    wr(8'h01, 8'h03);
    pulse(6'h04);
    rd(8'h00, 8'h40);
    wr(8'h01, 8'h07);
    clr(8'h40);
    pulse(6'h20);
    rd(8'h00, 8'h10);
    wr(8'h01, 8'h05);
    rd(8'h00, 8'h90);
    clr(8'h90);
    rd(8'h00, 8'h84);
    wr(8'h01, 8'h07);
    clr(8'h84);
    end_time(8'h00, 5);
    end_time(8'h10, 3);
    end_time(8'h08, 2);
    // normal meanings while smart card select is 0
    wr(8'h01, 8'h06);
    pulse(6'h01);
    @(posedge sys_clk);
    stp <= 1'b1;
    @(posedge sys_clk);
    stp <= 1'b0;
    rd(8'h00, 8'h84);
    @(posedge sys_clk);
    fe <= 1'b1;
    pulse(6'h04);
    fe <= 1'b0;
    rd(8'h00, 8'h94);
    @(posedge sys_clk);
    mpbi <= 1'b1;
    pulse(6'h04);
    mpbi <= 1'b0;
    rd(8'h00, 8'hd6);
    clr(8'hd6);
    rd(8'h00, 8'h02);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h1f);
    wrap_up;
  end
endmodule // scsf_status_test
